// *** hdl/fbs_pkg.sv ***
// Shared constants and types of the fieldbus slave output control block
package fbs_pkg;
	// ------------------------------------------------------------
	// Image and bus limits
	// ------------------------------------------------------------
	localparam int OUT_MAX = 246;
	localparam int IN_MAX = 246;
	localparam int STATIONS_MAX = 126;
	localparam logic [6:0] ADDR_BCAST = 7'h7F;
	localparam logic [7:0] IDX_SAT = 8'hFF;

	// ------------------------------------------------------------
	// Frame kinds delivered by the link decoder
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		K_DATA = 3'b000,
		K_PARAM = 3'b001,
		K_CONFIG = 3'b010,
		K_SYNC = 3'b011,
		K_UNSYNC = 3'b100,
		K_READ = 3'b101
	} fbs_kind_t;

	// ------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GROUP = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_DEVCFG = 8'h0C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0003;
	localparam logic [31:0] GROUP_RST = 32'h0000_0000;
	// Device type, format, output length, input length; values arbitrary
	localparam logic [31:0] DEVCFG_RST = 32'h0202_0001;
	localparam int ST_PRM = 0;
	localparam int ST_CFG = 1;
	localparam int ST_PEND = 2;
	localparam int ST_SYNC = 3;
	localparam int ST_SAFE = 4;
	localparam int ST_OWN_LO = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// Watchdog timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WD_TICK_NS = 1000000;
	localparam int WD_TICK_CYC = WD_TICK_NS / CLK_PERIOD_NS;
endpackage

// *** hdl/fbs_wd_if.sv ***
// Interface between the output controller and its response watchdog
`timescale 1ns/1ps
interface fbs_wd_if;
	logic restart;
	logic [7:0] interval_ms;
	logic expired;
	modport ctl (output restart, output interval_ms, input expired);
	modport dog (input restart, input interval_ms, output expired);
endinterface

// *** hdl/fbs_wdog.sv ***
// Response watchdog: counts millisecond ticks since the last restart
`timescale 1ns/1ps
module fbs_wdog import fbs_pkg::*; #(
	parameter int TICK_CYC = WD_TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	fbs_wd_if.dog wd
);
	typedef struct packed {
		logic [31:0] tick;
		logic [7:0] ms;
		logic run;
		logic exp;
	} fbs_wd_st_t;

	fbs_wd_st_t wd_ff;
	fbs_wd_st_t nxt_wd;

	always_comb begin
		nxt_wd = wd_ff;
		nxt_wd.exp = 1'b0;
		if (!aresetn) begin
			nxt_wd = '0;
		end else if (wd.restart || wd.interval_ms == 8'h00) begin
			// Interval of zero leaves the watchdog off
			nxt_wd.tick = '0;
			nxt_wd.ms = 8'h00;
			nxt_wd.run = wd.restart && wd.interval_ms != 8'h00;
		end else if (wd_ff.run) begin
			nxt_wd.tick = wd_ff.tick + 32'h0000_0001;
			if (wd_ff.tick == 32'(TICK_CYC - 1)) begin
				nxt_wd.tick = '0;
				nxt_wd.ms = wd_ff.ms + 8'h01;
				if (wd_ff.ms + 8'h01 == wd.interval_ms) begin
					nxt_wd.exp = 1'b1;
					nxt_wd.run = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		wd_ff <= nxt_wd;
	end

	assign wd.expired = wd_ff.exp;
endmodule

// *** hdl/fbs_slave_top.sv ***
// Fieldbus slave output control with AXI4-Lite register access
// Notes on behaviour
// - Input and output images each hold at most 246 bytes.
// - Only the assigned controller master writes outputs; every master may read.
// - Exchange starts only after parameter and matching configuration phases.
// - Control commands go multicast to one slave, a group or all slaves.
// - Sync command enters sync mode and freezes the output lines.
// - In sync mode new data is stored, applied only at next sync.
// - Unsync command leaves sync mode; data goes straight to lines again.
// - Slave watchdog with configured interval forces safe outputs on silence.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fbs_slave_top import fbs_pkg::*; #(
	parameter int TICK_CYC = WD_TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic rx_good,
	input wire logic [2:0] rx_kind,
	input wire logic [6:0] rx_src,
	input wire logic [6:0] rx_dst,
	input wire logic [7:0] rx_grp,
	input wire logic [7:0] rx_data,
	output logic [OUT_MAX*8-1:0] out_lines,
	output logic rsp_valid,
	output logic [6:0] rsp_dst,
	output logic data_exchange,
	output logic sync_mode,
	output logic safe_state
);
	typedef struct packed {
		logic [OUT_MAX-1:0][7:0] lines;
		logic [OUT_MAX-1:0][7:0] rxb;
		logic [OUT_MAX-1:0][7:0] img;
		logic [OUT_MAX-1:0][7:0] safev;
		logic [7:0] idx;
		fbs_kind_t kind;
		logic [6:0] src;
		logic hit;
		logic [6:0] owner;
		logic prm_ok;
		logic cfg_ok;
		logic sync;
		logic safe;
		logic img_new;
		logic [7:0] wd_ms;
		logic wd_kick;
		logic rsp;
		logic [6:0] rsp_dst;
		logic aw_ok;
		logic [7:0] awa;
		logic w_ok;
		logic [31:0] wdat;
		logic [3:0] wstb;
		logic bv;
		logic [1:0] bresp;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rresp;
		logic [31:0] ctrl;
		logic [31:0] grp;
		logic [31:0] devcfg;
	} fbs_st_t;

	fbs_st_t st_ff;
	fbs_st_t nxt_st;
	fbs_wd_if wdi ();
	fbs_kind_t cur_kind;
	logic [7:0] cur_idx;
	logic [6:0] cur_src;
	logic cur_hit;
	logic [31:0] status;

	fbs_wdog #(.TICK_CYC(TICK_CYC)) u_wdog (
		.aclk(aclk),
		.aresetn(aresetn),
		.wd(wdi)
	);

	assign wdi.restart = st_ff.wd_kick;
	assign wdi.interval_ms = st_ff.wd_ms;

	// Byte lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		status = '0;
		status[ST_PRM] = st_ff.prm_ok;
		status[ST_CFG] = st_ff.cfg_ok;
		status[ST_PEND] = st_ff.img_new;
		status[ST_SYNC] = st_ff.sync;
		status[ST_SAFE] = st_ff.safe;
		status[ST_OWN_LO +: 7] = st_ff.owner;
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rsp = 1'b0;
		nxt_st.wd_kick = 1'b0;
		cur_kind = rx_sof ? fbs_kind_t'(rx_kind) : st_ff.kind;
		cur_src = rx_sof ? rx_src : st_ff.src;
		cur_idx = rx_sof ? 8'h00 : st_ff.idx;
		// Multicast reach only for control commands; other frames are point to point
		cur_hit = rx_dst == st_ff.ctrl[6:0] || ((fbs_kind_t'(rx_kind) == K_SYNC
			|| fbs_kind_t'(rx_kind) == K_UNSYNC) && (rx_dst == ADDR_BCAST
			|| (rx_grp & st_ff.grp[7:0]) != 8'h00));
		if (!rx_sof) begin
			cur_hit = st_ff.hit;
		end
		// ------------------------------------------------------------
		// Frame reception
		// ------------------------------------------------------------
		if (rx_valid) begin
			nxt_st.kind = cur_kind;
			nxt_st.src = cur_src;
			nxt_st.hit = cur_hit;
			if (cur_idx < 8'(OUT_MAX)) begin
				nxt_st.rxb[cur_idx] = rx_data;
			end
			nxt_st.idx = (cur_idx == IDX_SAT) ? IDX_SAT : cur_idx + 8'h01;
			if (rx_eof && rx_good && cur_hit) begin
				nxt_st.wd_kick = 1'b1;
				unique case (cur_kind)
					K_PARAM: begin
						nxt_st.owner = cur_src;
						nxt_st.prm_ok = 1'b1;
						nxt_st.cfg_ok = 1'b0;
						nxt_st.wd_ms = nxt_st.rxb[0];
						nxt_st.safev = {8'h00, nxt_st.rxb[OUT_MAX-1:1]};
					end
					K_CONFIG: begin
						// Type, format and both lengths must all match
						nxt_st.cfg_ok = st_ff.prm_ok && cur_src == st_ff.owner
							&& nxt_st.rxb[3:0] == st_ff.devcfg;
					end
					K_DATA: begin
						// Foreign masters get the input image but cannot write
						nxt_st.rsp = 1'b1;
						nxt_st.rsp_dst = cur_src;
						if (st_ff.prm_ok && st_ff.cfg_ok && cur_src == st_ff.owner) begin
							if (st_ff.sync) begin
								nxt_st.img = nxt_st.rxb;
								nxt_st.img_new = 1'b1;
							end else begin
								nxt_st.lines = nxt_st.rxb;
								nxt_st.safe = 1'b0;
							end
						end
					end
					K_SYNC: begin
						if (st_ff.sync && st_ff.img_new) begin
							nxt_st.lines = st_ff.img;
							nxt_st.img_new = 1'b0;
							nxt_st.safe = 1'b0;
						end
						nxt_st.sync = 1'b1;
					end
					K_UNSYNC: begin
						nxt_st.sync = 1'b0;
						nxt_st.img_new = 1'b0;
					end
					K_READ: begin
						nxt_st.rsp = 1'b1;
						nxt_st.rsp_dst = cur_src;
					end
					default: begin
					end
				endcase
			end
		end
		// Expiry comes last so it wins over data arriving the same cycle
		if (wdi.expired) begin
			nxt_st.safe = 1'b1;
			nxt_st.lines = st_ff.safev;
		end
		// ------------------------------------------------------------
		// AXI4-Lite slave
		// ------------------------------------------------------------
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_ok = 1'b1;
			nxt_st.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_ok = 1'b1;
			nxt_st.wdat = s_axi_wdata;
			nxt_st.wstb = s_axi_wstrb;
		end
		if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bv) begin
			nxt_st.bv = 1'b1;
			nxt_st.aw_ok = 1'b0;
			nxt_st.w_ok = 1'b0;
			nxt_st.bresp = RESP_OKAY;
			unique case (st_ff.awa)
				REG_CTRL: nxt_st.ctrl = merge(st_ff.ctrl, st_ff.wdat, st_ff.wstb);
				REG_GROUP: nxt_st.grp = merge(st_ff.grp, st_ff.wdat, st_ff.wstb);
				REG_DEVCFG: nxt_st.devcfg = merge(st_ff.devcfg, st_ff.wdat, st_ff.wstb);
				REG_STATUS: begin
				end
				default: nxt_st.bresp = RESP_SLVERR;
			endcase
		end
		if (st_ff.bv && s_axi_bready) begin
			nxt_st.bv = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rv) begin
			nxt_st.rv = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: nxt_st.rd = {25'h0, st_ff.ctrl[6:0]};
				REG_GROUP: nxt_st.rd = {24'h0, st_ff.grp[7:0]};
				REG_STATUS: nxt_st.rd = status;
				REG_DEVCFG: nxt_st.rd = st_ff.devcfg;
				default: begin
					nxt_st.rd = '0;
					nxt_st.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st_ff.rv && s_axi_rready) begin
			nxt_st.rv = 1'b0;
		end
		// ------------------------------------------------------------
		// Reset
		// ------------------------------------------------------------
		if (!aresetn) begin
			nxt_st = '0;
			nxt_st.ctrl = CTRL_RST;
			nxt_st.grp = GROUP_RST;
			nxt_st.devcfg = DEVCFG_RST;
		end
	end

	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	assign s_axi_awready = !st_ff.aw_ok && !st_ff.bv;
	assign s_axi_wready = !st_ff.w_ok && !st_ff.bv;
	assign s_axi_bvalid = st_ff.bv;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = !st_ff.rv;
	assign s_axi_rvalid = st_ff.rv;
	assign s_axi_rdata = st_ff.rd;
	assign s_axi_rresp = st_ff.rresp;
	assign out_lines = st_ff.lines;
	assign rsp_valid = st_ff.rsp;
	assign rsp_dst = st_ff.rsp_dst;
	assign data_exchange = st_ff.prm_ok && st_ff.cfg_ok;
	assign sync_mode = st_ff.sync;
	assign safe_state = st_ff.safe;
endmodule

// *** verification/fbs_slave_sva.sv ***
// Concurrent checks on the ports of the slave output control block
`timescale 1ns/1ps
module fbs_slave_sva import fbs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic rx_good,
	input wire logic [2:0] rx_kind,
	input wire logic [6:0] rx_dst,
	input wire logic [OUT_MAX*8-1:0] out_lines,
	input wire logic rsp_valid,
	input wire logic data_exchange,
	input wire logic sync_mode,
	input wire logic safe_state
);
	// ----------
	// Frame header capture
	// ----------
	logic [2:0] kind_ff;
	logic [6:0] dst_ff;
	logic [2:0] kc;
	logic [6:0] dc;
	logic eok;
	// Header fields are valid with the first byte only, so hold them to the end
	assign kc = rx_sof ? rx_kind : kind_ff;
	assign dc = rx_sof ? rx_dst : dst_ff;
	assign eok = rx_valid && rx_eof && rx_good;
	always_ff @(posedge aclk) begin
		if (rx_valid && rx_sof) begin
			kind_ff <= rx_kind;
			dst_ff <= rx_dst;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------
	// Properties
	// ----------
	a_sync_enter: assert property (eok && kc == K_SYNC && dc == ADDR_BCAST |=> sync_mode)
		else $error("sync command left sync mode off");
	a_unsync_exit: assert property (eok && kc == K_UNSYNC && dc == ADDR_BCAST |=> !sync_mode)
		else $error("unsync command left sync mode on");
	a_sync_freeze: assert property (sync_mode && $past(sync_mode) && !$rose(safe_state)
		&& !($past(eok) && $past(kc) == K_SYNC) |-> $stable(out_lines))
		else $error("lines moved in sync mode without sync");
	a_lines_cause: assert property ($changed(out_lines) |-> $past(eok) || $rose(safe_state))
		else $error("lines moved without frame or expiry");
	a_safe_leave: assert property ($fell(safe_state) |-> $past(eok))
		else $error("safe state left without a frame");
	a_rsp_cause: assert property (rsp_valid |-> $past(eok)
		&& ($past(kc) == K_DATA || $past(kc) == K_READ))
		else $error("reply without a good data or read frame");
	a_xchg_gate: assert property (eok && kc == K_DATA && !data_exchange && !sync_mode
		|=> $stable(out_lines) || $rose(safe_state))
		else $error("data applied before exchange allowed");
	a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
endmodule

// *** verification/fbs_master_model.sv ***
// Behavioural cyclic controller master feeding decoded frames to the slave
`timescale 1ns/1ps
module fbs_master_model import fbs_pkg::*; (
	input wire logic aclk,
	output logic rx_valid,
	output logic rx_sof,
	output logic rx_eof,
	output logic rx_good,
	output logic [2:0] rx_kind,
	output logic [6:0] rx_src,
	output logic [6:0] rx_dst,
	output logic [7:0] rx_grp,
	output logic [7:0] rx_data
);
	initial begin
		{rx_valid, rx_sof, rx_eof, rx_good, rx_kind, rx_src, rx_dst, rx_grp, rx_data} = '0;
	end
	// ----------
	// Controller master state; every test runs in operate
	// ----------
	typedef enum logic [1:0] {
		M_STOP = 2'b00,
		M_CLEAR = 2'b01,
		M_OPER = 2'b10
	} fbs_mst_t;
	// Exchange interval in cycles; short so a quiet spell shows up quickly
	localparam int XCHG_LIMIT = 50;
	fbs_mst_t mode = M_OPER;
	logic auto_clear = 1'b1;
	logic [STATIONS_MAX-1:0] excluded = '0;
	logic [6:0] dst_ff = 7'h00;
	int xtimer_ff [STATIONS_MAX];
	logic [STATIONS_MAX-1:0] late_ff = '0;
	// One exchange timer per slave, cleared by each good data frame to it
	always @(posedge aclk) begin
		if (rx_valid && rx_sof) begin
			dst_ff <= rx_dst;
		end
		for (int i = 0; i < STATIONS_MAX; i++) begin
			if (rx_valid && rx_eof && rx_good && rx_kind == K_DATA
				&& (rx_sof ? rx_dst : dst_ff) == 7'(i)) begin
				xtimer_ff[i] <= 0;
				late_ff[i] <= 1'b0;
			end else begin
				xtimer_ff[i] <= xtimer_ff[i] + 1;
				late_ff[i] <= late_ff[i] || xtimer_ff[i] >= XCHG_LIMIT;
			end
		end
	end
	// Master diagnostics read: which slaves missed their exchange interval
	task diag(output logic [STATIONS_MAX-1:0] late);
		late = late_ff;
	endtask
	// Planning master services: change state, switch one slave's exchange
	task plan(input fbs_mst_t m, input logic [6:0] a, input logic off);
		mode = m;
		excluded[a] = off;
	endtask
	// A lost slave: auto clear drops to clear, otherwise the master goes to operate
	task lost;
		if (auto_clear) begin
			mode = M_CLEAR;
		end else begin
			mode = M_OPER;
		end
	endtask
	// Bytes go out low byte first, back to back, one per cycle
	task send(input logic [2:0] k, input logic [6:0] s, input logic [6:0] d,
		input logic [7:0] g, input logic [31:0] w, input int n, input logic ok);
		logic [2:0] kk;
		if (k == K_DATA && mode == M_STOP) begin
			return;
		end
		if (k == K_DATA && d < 7'(STATIONS_MAX) && excluded[d]) begin
			return;
		end
		if (d >= 7'(STATIONS_MAX) && d != ADDR_BCAST) begin
			return;
		end
		// Clear mode only reads inputs, so slave outputs keep their safe value
		kk = (k == K_DATA && mode == M_CLEAR) ? K_READ : k;
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_eof <= (i == n - 1);
			rx_good <= ok;
			rx_kind <= kk;
			rx_src <= s;
			rx_dst <= d;
			rx_grp <= g;
			rx_data <= w[8*i+:8];
		end
		@(posedge aclk);
		// Released lines must not look like a held last byte
		{rx_valid, rx_sof, rx_eof} <= 3'h0;
		{rx_good, rx_kind, rx_src, rx_dst, rx_grp} <= ~{ok, k, s, d, g};
		rx_data <= ~rx_data;
	endtask
endmodule

// *** verification/test_fieldbus_slave_output_control.sv ***
// Testbench for the fieldbus slave output control block
`timescale 1ns/1ps
module test_fieldbus_slave_output_control import fbs_pkg::*; ;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, rx_kind;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, lo;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic rx_valid, rx_sof, rx_eof, rx_good, rsp_valid, data_exchange, sync_mode, safe_state;
	logic [6:0] rx_src, rx_dst, rsp_dst;
	logic [7:0] rx_grp, rx_data;
	logic [OUT_MAX*8-1:0] out_lines;
	int n_mismatch, num_checks;
	assign lo = {16'h0, out_lines[15:0]};
	fbs_slave_top #(.TICK_CYC(10)) u_fbs_slave_top (.*);
	fbs_master_model u_fbs_master_model (.*);
	// ----------
	// Helpers
	// ----------
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ka, kw, kb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		kb = 1'b0;
		while (!kb) begin
			@(negedge aclk);
			ka = s_axi_awvalid && s_axi_awready;
			kw = s_axi_wvalid && s_axi_wready;
			kb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ka) s_axi_awvalid <= 1'b0;
			if (kw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ka, kr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		kr = 1'b0;
		while (!kr) begin
			@(negedge aclk);
			ka = s_axi_arvalid && s_axi_arready;
			kr = s_axi_rvalid;
			v = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ka) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	// Effects land one cycle after the last byte; look at them mid-cycle
	task fr(input logic [2:0] k, input logic [6:0] s, input logic [6:0] t, input logic [7:0] g,
		input logic [31:0] w, input int n, input logic ok);
		u_fbs_master_model.send(k, s, t, g, w, n, ok);
		@(negedge aclk);
	endtask
	// ----------
	// Scenarios
	// ----------
	task t_regs;
		axr(REG_CTRL, d, r);
		chk(d, CTRL_RST);
		axr(REG_GROUP, d, r);
		chk(d, GROUP_RST);
		axr(REG_DEVCFG, d, r);
		chk(d, DEVCFG_RST);
		axr(8'h10, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axw(8'h10, 32'h0000_0001, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axw(REG_GROUP, 32'h0000_0001, r);
		chk(32'(r), 32'(RESP_OKAY));
		axr(REG_GROUP, d, r);
		chk(d, 32'h0000_0001);
	endtask
	task t_gate;
		fr(K_DATA, 7'h01, 7'h03, 8'h00, 32'h0000_BBAA, 2, 1'b1);
		chk(lo, 32'h0);
		fr(K_PARAM, 7'h01, 7'h03, 8'h00, 32'h00A5_5A08, 3, 1'b1);
		fr(K_CONFIG, 7'h01, 7'h03, 8'h00, DEVCFG_RST ^ 32'h0000_0100, 4, 1'b1);
		chk(32'(data_exchange), 32'h0);
		fr(K_CONFIG, 7'h01, 7'h03, 8'h00, DEVCFG_RST, 4, 1'b1);
		chk(32'(data_exchange), 32'h1);
		axr(REG_STATUS, d, r);
		chk(d, (32'h1 << ST_PRM) | (32'h1 << ST_CFG) | (32'h1 << ST_OWN_LO));
	endtask
	task t_data;
		fr(K_DATA, 7'h01, 7'h03, 8'h00, 32'h0000_BBAA, 2, 1'b1);
		chk(lo, 32'h0000_BBAA);
		chk(32'({rsp_valid, rsp_dst}), 32'h81);
		fr(K_DATA, 7'h02, 7'h03, 8'h00, 32'h0000_1111, 2, 1'b1);
		chk(lo, 32'h0000_BBAA);
		chk(32'({rsp_valid, rsp_dst}), 32'h82);
		fr(K_READ, 7'h04, 7'h03, 8'h00, 32'h0, 1, 1'b1);
		chk(32'({rsp_valid, rsp_dst}), 32'h84);
		chk(lo, 32'h0000_BBAA);
		fr(K_DATA, 7'h01, 7'h03, 8'h00, 32'h0000_2222, 2, 1'b0);
		chk(lo, 32'h0000_BBAA);
	endtask
	task t_sync;
		fr(K_SYNC, 7'h01, 7'h05, 8'h01, 32'h0, 1, 1'b1);
		chk(32'(sync_mode), 32'h1);
		fr(K_DATA, 7'h01, 7'h03, 8'h00, 32'h0000_2211, 2, 1'b1);
		chk(lo, 32'h0000_BBAA);
		fr(K_SYNC, 7'h01, ADDR_BCAST, 8'h00, 32'h0, 1, 1'b1);
		chk(lo, 32'h0000_2211);
		fr(K_UNSYNC, 7'h01, ADDR_BCAST, 8'h00, 32'h0, 1, 1'b1);
		chk(32'(sync_mode), 32'h0);
		fr(K_DATA, 7'h01, 7'h03, 8'h00, 32'h0000_4433, 2, 1'b1);
		chk(lo, 32'h0000_4433);
	endtask
	task t_wd;
		repeat (60) @(negedge aclk);
		chk(32'(safe_state), 32'h0);
		for (int i = 0; i < 60 && safe_state !== 1'b1; i++) @(negedge aclk);
		chk(32'(safe_state), 32'h1);
		chk(lo, 32'h0000_A55A);
		fr(K_DATA, 7'h01, 7'h03, 8'h00, 32'h0000_6655, 2, 1'b1);
		chk(32'(safe_state), 32'h0);
		chk(lo, 32'h0000_6655);
		fr(K_PARAM, 7'h01, 7'h03, 8'h00, 32'h0033_2200, 3, 1'b1);
		chk(32'(data_exchange), 32'h0);
	endtask
	task test_done;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		n_mismatch = 0;
		num_checks = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_gate();
		t_data();
		t_sync();
		t_wd();
		test_done();
	end
	// Whole run is under two hundred cycles
	initial begin
		#20000;
		n_mismatch++;
		test_done();
	end
endmodule
bind fbs_slave_top fbs_slave_sva u_fbs_slave_sva (.*);
